// file: rtl/dsr_pkg.sv
// package: offsets, field positions and reset values of the diagnostic status bank
package dsr_pkg;
  localparam int unsigned DSR_WORD_W = 24;
  localparam logic [5:0] DSR_OFS_THERM = 6'h02;
  localparam logic [5:0] DSR_OFS_SUPPLY = 6'h03;
  localparam logic [5:0] DSR_OFS_LEVEL = 6'h04;
  localparam logic [5:0] DSR_OFS_OPEN = 6'h05;
  // word two fields
  localparam int unsigned DSR_THERM_LSB = 16;
  localparam int unsigned DSR_SHORT_LSB = 11;
  // word three fields
  localparam int unsigned DSR_GND_LOST_BIT = 5;
  localparam int unsigned DSR_IP_LOW_BIT = 4;
  localparam int unsigned DSR_CAN_LOW_BIT = 3;
  // word four fields
  localparam int unsigned DSR_WD_LSB = 22;
  localparam int unsigned DSR_EI2_BIT = 21;
  localparam int unsigned DSR_EI1_BIT = 18;
  // word five fields
  localparam int unsigned DSR_DRIVER_ZERO_OPEN_LOAD_FLAG_BIT = 21;
  localparam int unsigned DSR_HS_HI_LSB = 16;
  localparam int unsigned DSR_HS_LO_LSB = 12;
  localparam int unsigned DSR_HB_OL_LSB = 6;
  // watchdog progress encodings
  localparam logic [1:0] DSR_WD_FIRST = 2'h0;
  localparam logic [1:0] DSR_WD_SECOND = 2'h1;
  localparam logic [1:0] DSR_WD_LAST = 2'h3;
  localparam logic [23:0] DSR_RESET_WORD = 24'h000000;
  typedef enum logic [1:0] {DSR_PH_FIRST, DSR_PH_SECOND, DSR_PH_LAST} dsr_phase_t;
endpackage

// file: rtl/dsr_status_bank.sv
// diagnostic status words two to five with read-and-clear access
//
// How it works
// RULE_01: word two bits 23..16 latch thermal shutdown of clusters eight..one.
// RULE_02: a cluster crossing its threshold switches all its outputs off with the flag.
// RULE_03: word two bits 13..11 latch high-side shorts of bridges six..four.
// RULE_04: latched flags stay set until a read-and-clear of their word.
// RULE_05: word three bit 5 follows ground loss live, unlatched.
// RULE_06: word three bit 4 latches internal supply below 3V.
// RULE_07: word three bit 3 latches transceiver supply low warning.
// RULE_08: word four bits 23:22 show watchdog progress 00, 01, 11; 10 never.
// RULE_09: word four bit 21 is live input two level, untouched by clears.
// RULE_10: input two level reads 0 unless configured as wake-up input.
// RULE_11: word four bit 18 is live input one level, never cleared.
// RULE_12: word five latches driver open-load flags at bits 21, 20..16, 14..12.
// RULE_13: word five latches bridge open-load pairs at bits 11..6.
// RULE_14: reserved positions always read zero.
// RULE_15: host never writes status words; such frames are refused, flagged invalid.
// RULE_16: read-and-clear returns pre-clear values; persisting conditions set again.
// RULE_17: an event in the clear cycle wins; flag ends set.
`timescale 1ns/1ps
`default_nettype none
module dsr_status_bank
  import dsr_pkg::*;
(
  input  wire logic        CORE_CLK,
  input  wire logic        RST_B,
  // access port from the serial frame logic
  input  wire logic        ACC_VALID,
  input  wire logic        ACC_WRITE,
  input  wire logic        ACC_CLEAR,
  input  wire logic [5:0]  ACC_ADDR,
  output logic [23:0]      ACC_RDATA,
  output logic             ACC_HIT,
  output logic             ACC_INV_CMD,
  // detector events, same clock domain
  input  wire logic [7:0]  THERM_TRIP,
  input  wire logic [2:0]  HIGH_SHORT,
  input  wire logic        INTERNAL_SUPPLY_LOW_FLAG_EV,
  input  wire logic        TRANSCEIVER_SUPPLY_LOW_FLAG_EV,
  input  wire logic [8:0]  DRV_OPEN_LOAD,
  input  wire logic [5:0]  HB_OPEN_LOAD,
  // live conditions
  input  wire logic        GND_LOST,
  input  wire logic [1:0]  WD_PHASE,
  input  wire logic        EXT_IN_ONE,
  input  wire logic        EXT_IN_TWO,
  input  wire logic        EXT_TWO_WAKE_CFG,
  // cluster output enables after shutdown
  input  wire logic [7:0]  CLUSTER_ON_REQ,
  output logic [7:0]       CLUSTER_ON
);
  // ----------------------------------------------
  // address decode
  // ----------------------------------------------
  // shared by all four word selects
  function automatic logic hit_of(input logic [5:0] a, input logic [5:0] ofs);
    hit_of = (a == ofs);
  endfunction

  logic sel_therm;
  logic sel_supply;
  logic sel_level;
  logic sel_open;
  logic any_sel;
  logic rd_ok;
  logic clr_therm;
  logic clr_supply;
  logic clr_open;

  assign sel_therm  = hit_of(ACC_ADDR, DSR_OFS_THERM);
  assign sel_supply = hit_of(ACC_ADDR, DSR_OFS_SUPPLY);
  assign sel_level  = hit_of(ACC_ADDR, DSR_OFS_LEVEL);
  assign sel_open   = hit_of(ACC_ADDR, DSR_OFS_OPEN);
  assign any_sel    = sel_therm | sel_supply | sel_level | sel_open;
  assign rd_ok      = ACC_VALID & ~ACC_WRITE & any_sel;
  // word four is live only, so a clear there has nothing to act on;
  // a write never clears: one to a status word is refused and only pulses the invalid flag
  assign clr_therm  = rd_ok & ACC_CLEAR & sel_therm;
  assign clr_supply = rd_ok & ACC_CLEAR & sel_supply;
  assign clr_open   = rd_ok & ACC_CLEAR & sel_open;

  // ----------------------------------------------
  // live input synchronisers
  // ----------------------------------------------
  // one shared synchroniser keeps the live bits on a common lag of four edges;
  // a phase code whose pins skew can show a mixed value for a cycle,
  // which the decode below folds onto a legal code
  logic [4:0] live_s;
  dsr_sync3 #(.W(5)) u_sync (
    .CORE_CLK (CORE_CLK),
    .RST_B    (RST_B),
    .D_IN     ({GND_LOST, WD_PHASE, EXT_IN_ONE, EXT_IN_TWO}),
    .Q_OUT    (live_s)
  );

  logic       gnd_s;
  logic [1:0] wd_s;
  logic       ei1_s;
  logic       ei2_s;
  logic [1:0] wd_code;
  assign gnd_s = live_s[4];
  assign wd_s  = live_s[3:2];
  assign ei1_s = live_s[1];
  assign ei2_s = live_s[0];

  // invalid phase code is never shown; held at last third
  always_comb begin
    case (wd_s)
      DSR_WD_FIRST:  wd_code = DSR_WD_FIRST;
      DSR_WD_SECOND: wd_code = DSR_WD_SECOND;
      default:       wd_code = DSR_WD_LAST; // RULE_08
    endcase
  end

  // ----------------------------------------------
  // latched flags
  // ----------------------------------------------
  logic [7:0]  therm_q;
  logic [7:0]  therm_d;
  logic [2:0]  short_q;
  logic [2:0]  short_d;
  logic [1:0]  sup_q;
  logic [1:0]  sup_d;
  logic [8:0]  dol_q;
  logic [8:0]  dol_d;
  logic [5:0]  hol_q;
  logic [5:0]  hol_d;

  // set wins over clear so no event is lost
  // an event in the clear cycle is seen on the next read, not dropped;
  // a condition that persists simply sets its flag again after a clear
  assign therm_d = (therm_q & ~{8{clr_therm}}) | THERM_TRIP; // RULE_01 RULE_04 RULE_17
  assign short_d = (short_q & ~{3{clr_therm}}) | HIGH_SHORT; // RULE_03 RULE_04 RULE_17
  assign sup_d   = (sup_q & ~{2{clr_supply}})
                 | {INTERNAL_SUPPLY_LOW_FLAG_EV, TRANSCEIVER_SUPPLY_LOW_FLAG_EV}; // RULE_06 RULE_07 RULE_16
  assign dol_d   = (dol_q & ~{9{clr_open}}) | DRV_OPEN_LOAD; // RULE_12 RULE_16
  assign hol_d   = (hol_q & ~{6{clr_open}}) | HB_OPEN_LOAD; // RULE_13 RULE_17

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      therm_q <= '0;
      short_q <= '0;
      sup_q   <= '0;
      dol_q   <= '0;
      hol_q   <= '0;
    end else begin
      therm_q <= therm_d;
      short_q <= short_d;
      sup_q   <= sup_d;
      dol_q   <= dol_d;
      hol_q   <= hol_d;
    end
  end

  // cut the cluster at once, combinational so the cut starts in the trip cycle, one edge before the flag sets
  // the cut lasts while the flag stands; a clear lets the request through again
  assign CLUSTER_ON = CLUSTER_ON_REQ & ~(therm_q | THERM_TRIP); // RULE_02

  // ----------------------------------------------
  // word assembly, reserved bits zero
  // ----------------------------------------------
  logic [23:0] w_therm;
  logic [23:0] w_supply;
  logic [23:0] w_level;
  logic [23:0] w_open;
  logic        ei2_shown;

  assign ei2_shown = ei2_s & EXT_TWO_WAKE_CFG; // RULE_10

  always_comb begin
    // reserved positions start from the reset word and are never written,
    // so they read zero whatever the detectors do
    w_therm  = DSR_RESET_WORD;
    w_supply = DSR_RESET_WORD;
    w_level  = DSR_RESET_WORD;
    w_open   = DSR_RESET_WORD; // RULE_14
    w_therm[DSR_THERM_LSB +: 8] = therm_q;
    w_therm[DSR_SHORT_LSB +: 3] = short_q;
    w_supply[DSR_GND_LOST_BIT]  = gnd_s; // RULE_05
    w_supply[DSR_IP_LOW_BIT]    = sup_q[1];
    w_supply[DSR_CAN_LOW_BIT]   = sup_q[0];
    w_level[DSR_WD_LSB +: 2]    = wd_code;
    w_level[DSR_EI2_BIT]        = ei2_shown; // RULE_09
    w_level[DSR_EI1_BIT]        = ei1_s; // RULE_11
    w_open[DSR_DRIVER_ZERO_OPEN_LOAD_FLAG_BIT]      = dol_q[8];
    w_open[DSR_HS_HI_LSB +: 5]  = dol_q[7:3];
    w_open[DSR_HS_LO_LSB +: 3]  = dol_q[2:0];
    w_open[DSR_HB_OL_LSB +: 6]  = hol_q;
  end

  // one word at most is selected, so an or of masked words is enough
  logic [23:0] rdata_d;
  assign rdata_d = ({24{sel_therm}} & w_therm) | ({24{sel_supply}} & w_supply)
                 | ({24{sel_level}} & w_level) | ({24{sel_open}} & w_open);

  // ----------------------------------------------
  // answer registers
  // ----------------------------------------------
  logic [23:0] rdata_q;
  logic        hit_q;
  logic        inv_q;

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      rdata_q <= '0;
      hit_q   <= 1'b0;
      inv_q   <= 1'b0;
    end else begin
      rdata_q <= rd_ok ? rdata_d : rdata_q; // RULE_16
      hit_q   <= rd_ok;
      inv_q   <= ACC_VALID & ACC_WRITE & any_sel; // RULE_15
    end
  end

  // read data holds between reads so a slow sampler still sees the word;
  // an unmapped address gives neither a hit nor a refusal and leaves it as is;
  // the refusal pulse is this bank's share, the frame logic keeps the sticky flag
  assign ACC_RDATA   = rdata_q;
  assign ACC_HIT     = hit_q;
  assign ACC_INV_CMD = inv_q;
endmodule
`default_nettype wire

// file: rtl/dsr_sync3.sv
// three-stage input synchroniser; output changes when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module dsr_sync3 #(
  parameter int unsigned W = 1
) (
  input  wire logic         CORE_CLK,
  input  wire logic         RST_B,
  input  wire logic [W-1:0] D_IN,
  output logic      [W-1:0] Q_OUT
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] out_q;
  logic [W-1:0] agree;
  logic [W-1:0] out_d;

  assign agree = ~(s2_q ^ s3_q);
  assign out_d = (agree & s3_q) | (~agree & out_q);
  assign Q_OUT = out_q;

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      out_q <= '0;
    end else begin
      s1_q  <= D_IN;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      out_q <= out_d;
    end
  end
endmodule
`default_nettype wire

// file: verif/diag_status_regs_two_to_five_bench.sv
// self-checking bench for the diagnostic status bank
`timescale 1ns/1ps
`default_nettype none
module diag_status_regs_two_to_five_bench;
  logic        clk, rst_b, e1, e2, wcfg, gnd, ipl, canl, valid, wr, clr, hit, inv;
  logic [1:0]  wd;
  logic [2:0]  hs;
  logic [5:0]  addr, hol;
  logic [7:0]  trip, req, con;
  logic [8:0]  dol;
  logic [23:0] rdata;
  int          n_mismatch, comparisons;
  dsr_status_bank dut_u (.CORE_CLK(clk), .RST_B(rst_b), .ACC_VALID(valid), .ACC_WRITE(wr),
    .ACC_CLEAR(clr), .ACC_ADDR(addr), .ACC_RDATA(rdata), .ACC_HIT(hit), .ACC_INV_CMD(inv),
    .THERM_TRIP(trip), .HIGH_SHORT(hs), .INTERNAL_SUPPLY_LOW_FLAG_EV(ipl), .TRANSCEIVER_SUPPLY_LOW_FLAG_EV(canl),
    .DRV_OPEN_LOAD(dol), .HB_OPEN_LOAD(hol), .GND_LOST(gnd), .WD_PHASE(wd),
    .EXT_IN_ONE(e1), .EXT_IN_TWO(e2), .EXT_TWO_WAKE_CFG(wcfg), .CLUSTER_ON_REQ(req),
    .CLUSTER_ON(con));
  dsr_host host_u (.clk(clk), .hit(hit), .inv(inv), .rdata(rdata), .valid(valid),
    .wr(wr), .clr(clr), .addr(addr));
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // hi is the expected {hit, refused} pair; data only judged on a hit
  task automatic rd(input logic w, input logic [5:0] a, input logic [1:0] hi,
                    input logic [23:0] exp);
    logic [23:0] d;
    logic        h, i;
    @(posedge clk);
    host_u.acc(w, !w, a, d, h, i);
    chk({22'h0, h, i}, {22'h0, hi});
    if (hi[1]) chk(d, exp);
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_therm;
    @(posedge clk);
    trip <= 8'h81;
    hs <= 3'h5;
    fork
      rd(1'b0, 6'h02, 2'h2, 24'h812800);
      begin
        @(posedge clk);
        trip <= 8'h00;
        hs <= 3'h0;
        #1 chk({16'h0, con}, 24'h00007E);
      end
    join
    rd(1'b0, 6'h02, 2'h2, 24'h000000);
    chk({16'h0, con}, 24'h0000FF);
    fork
      rd(1'b0, 6'h02, 2'h2, 24'h000000);
      begin
        @(posedge clk);
        trip <= 8'h01;
        @(posedge clk);
        trip <= 8'h00;
      end
    join
    rd(1'b0, 6'h02, 2'h2, 24'h010000);
    $display("t_therm done");
  endtask
  task automatic t_sup;
    @(posedge clk);
    gnd <= 1'b1;
    ipl <= 1'b1;
    canl <= 1'b1;
    @(posedge clk);
    ipl <= 1'b0;
    canl <= 1'b0;
    repeat (6) @(posedge clk);
    rd(1'b0, 6'h03, 2'h2, 24'h000038);
    @(posedge clk);
    gnd <= 1'b0;
    repeat (6) @(posedge clk);
    rd(1'b0, 6'h03, 2'h2, 24'h000000);
    $display("t_sup done");
  endtask
  task automatic t_lvl;
    logic [1:0] ph [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
    logic [1:0] ex [4] = '{2'h0, 2'h1, 2'h3, 2'h3};
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      wd <= ph[k];
      e1 <= k[0];
      e2 <= 1'b1;
      wcfg <= (k != 1);
      repeat (6) @(posedge clk);
      rd(1'b0, 6'h04, 2'h2, {ex[k], k != 1, 2'h0, k[0], 18'h0});
    end
    rd(1'b0, 6'h04, 2'h2, 24'hE40000);
    $display("t_lvl done");
  endtask
  task automatic t_open;
    @(posedge clk);
    dol <= 9'h101;
    hol <= 6'h21;
    @(posedge clk);
    dol <= 9'h000;
    hol <= 6'h00;
    rd(1'b0, 6'h05, 2'h2, 24'h201840);
    rd(1'b1, 6'h02, 2'h1, 24'h000000);
    rd(1'b0, 6'h06, 2'h0, 24'h000000);
    $display("t_open done");
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    {rst_b, trip, hs, ipl, canl, dol, hol, gnd, wd, e1, e2, wcfg} = '0;
    req = 8'hFF;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    t_therm();
    t_sup();
    t_lvl();
    t_open();
    complete_run();
  end
  // tests need under 100 cycles; 5000 leaves ample room
  initial begin
    #40000;
    n_mismatch++;
    complete_run();
  end
endmodule
bind dsr_status_bank dsr_status_bank_chk chk_u (.CORE_CLK(CORE_CLK), .RST_B(RST_B),
  .ACC_VALID(ACC_VALID), .ACC_WRITE(ACC_WRITE), .ACC_CLEAR(ACC_CLEAR), .ACC_ADDR(ACC_ADDR),
  .ACC_RDATA(ACC_RDATA), .ACC_HIT(ACC_HIT), .ACC_INV_CMD(ACC_INV_CMD),
  .THERM_TRIP(THERM_TRIP), .CLUSTER_ON(CLUSTER_ON));
`default_nettype wire

// file: verif/dsr_host.sv
// host side model issuing status word accesses
`timescale 1ns/1ps
`default_nettype none
module dsr_host (
  input  wire logic        clk,
  input  wire logic        hit,
  input  wire logic        inv,
  input  wire logic [23:0] rdata,
  output logic             valid,
  output logic             wr,
  output logic             clr,
  output logic [5:0]       addr
);
  initial {valid, wr, clr, addr} = 9'h000;
  // one-cycle strobe; a write is only sent when a test wants a refusal
  task automatic acc(input logic w, input logic c, input logic [5:0] a,
                     output logic [23:0] d, output logic h, output logic i);
    valid <= 1'b1;
    wr <= w;
    clr <= c;
    addr <= a;
    @(posedge clk);
    valid <= 1'b0;
    @(negedge clk);
    d = rdata;
    h = hit;
    i = inv;
  endtask
endmodule
`default_nettype wire

// file: verif/dsr_status_bank_chk.sv
// port assertions for the diagnostic status bank
`timescale 1ns/1ps
`default_nettype none
module dsr_status_bank_chk (
  input  wire logic        CORE_CLK,
  input  wire logic        RST_B,
  input  wire logic        ACC_VALID,
  input  wire logic        ACC_WRITE,
  input  wire logic        ACC_CLEAR,
  input  wire logic [5:0]  ACC_ADDR,
  input  wire logic [23:0] ACC_RDATA,
  input  wire logic        ACC_HIT,
  input  wire logic        ACC_INV_CMD,
  input  wire logic [7:0]  THERM_TRIP,
  input  wire logic [7:0]  CLUSTER_ON
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);
  // ----
  // address of the last taken access selects the reserved mask
  // ----
  logic [5:0]  addr_q;
  wire         in_map = (ACC_ADDR >= 6'h02) && (ACC_ADDR <= 6'h05);
  wire  [23:0] rsv = (addr_q == 6'h02) ? 24'h00C7FF : (addr_q == 6'h03) ? 24'hFFFFC7 :
                     (addr_q == 6'h04) ? 24'h13FFFF : 24'hC0803F;
  always_ff @(posedge CORE_CLK or negedge RST_B)
    if (!RST_B) addr_q <= 6'h00;
    else if (ACC_VALID) addr_q <= ACC_ADDR;
  property p_hit; ACC_VALID && !ACC_WRITE && in_map |=> ACC_HIT; endproperty
  a_hit: assert property (p_hit) else $error("read not answered");
  property p_wr; ACC_VALID && ACC_WRITE && in_map |=> ACC_INV_CMD && !ACC_HIT; endproperty
  a_wr: assert property (p_wr) else $error("write not refused");
  property p_rsv; ACC_HIT |-> (ACC_RDATA & rsv) == 24'h000000; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bit set");
  property p_off; (CLUSTER_ON & THERM_TRIP) == 8'h00; endproperty
  a_off: assert property (p_off) else $error("tripped cluster on");
  property p_win; THERM_TRIP != 8'h00 |=> (CLUSTER_ON & $past(THERM_TRIP)) == 8'h00; endproperty
  a_win: assert property (p_win) else $error("trip lost");
  property p_tsd; THERM_TRIP[7] ##1 ACC_VALID && !ACC_WRITE && ACC_ADDR == 6'h02
    |=> ACC_RDATA[23]; endproperty
  a_tsd: assert property (p_tsd) else $error("cluster eight flag missing");
  property p_wd; ACC_HIT && addr_q == 6'h04 |-> ACC_RDATA[23:22] != 2'h2; endproperty
  a_wd: assert property (p_wd) else $error("bad watchdog code");
  property p_clr; ACC_VALID && !ACC_WRITE && ACC_CLEAR && ACC_ADDR == 6'h02
    && THERM_TRIP == 8'h00 ##1 !ACC_VALID && THERM_TRIP == 8'h00
    ##1 ACC_VALID && !ACC_WRITE && ACC_ADDR == 6'h02 && THERM_TRIP == 8'h00
    |=> ACC_RDATA[23:16] == 8'h00; endproperty
  a_clr: assert property (p_clr) else $error("flag survived clear");
endmodule
`default_nettype wire
